// *** hw/ssb_regs.svh ***
`ifndef SSB_REGS_SVH
`define SSB_REGS_SVH

// Register byte offsets
`define SSB_CFG_ADDR   8'h00
`define SSB_STAT_ADDR  8'h04
`define SSB_HOLD_ADDR  8'h08

// Configuration reset value: addressed protocol, all options 0, max ID 3
`define SSB_CFG_RST    32'h0000_0C00

// Sensor data width
`define SSB_DATA_W     16

// Tick timing
`define SSB_CLK_NS     10
`define SSB_TICK_NS    3000
`define SSB_TICK_CYC   ((`SSB_TICK_NS + `SSB_CLK_NS - 1) / `SSB_CLK_NS)

// Low pulse windows in ticks
`define SSB_INC_MIN    8'h03
`define SSB_INC_MAX    8'h07
`define SSB_OUT_MIN    8'h09
`define SSB_OUT_MAX    8'h28
`define SSB_SAMP_MIN   8'h29
`define SSB_SAMP_MAX   8'h37
`define SSB_DIAG_MIN   8'h38
`define SSB_DIAG_MAX   8'h46
`define SSB_SYNC_MIN   8'h5D
`define SSB_SYNC_MAX   8'h73

// High time limits in ticks
`define SSB_INC_END    10'h012
`define SSB_IDLE       10'h1FE
`define SSB_MARK_01    10'h00C
`define SSB_MARK_12    10'h01B
`define SSB_MARK_23    10'h031

// Pipeline flush length in clock cycles
`define SSB_FLUSH      3'h4

`endif

// *** hw/ssb_pkg.sv ***
package ssb_pkg;
  `include "ssb_regs.svh"

  typedef enum logic [2:0] {
    SSB_OFF  = 3'b001,
    SSB_SYNC = 3'b010,
    SSB_ON   = 3'b100
  } ssb_mode_t;

  typedef enum logic [2:0] {
    PK_NONE, PK_INC, PK_OUT, PK_SAMP, PK_DIAG, PK_SYNC
  } ssb_pulse_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic [1:0]  max_id;
    logic [1:0]  sensor_id;
    logic        idle_sync;
    logic        ss;
    logic        po;
    logic        zs;
    logic        da;
    logic        fa;
    logic        ns;
    logic        seq;
  } ssb_cfg_t;

  typedef struct packed {
    logic                   req;
    logic                   held;
    logic [`SSB_DATA_W-1:0] data;
  } ssb_frame_t;

  typedef struct packed {
    logic                   sync1;
    logic                   sync2;
    logic                   line_d;
    ssb_mode_t              mode;
    logic [15:0]            tick;
    logic [7:0]             low_ticks;
    logic [9:0]             high_ticks;
    logic [2:0]             flush;
    logic                   por_pend;
    ssb_cfg_t               cfg;
    logic [1:0]             slot;
    logic                   collect;
    logic [1:0]             inc_cnt;
    ssb_pulse_t             pend;
    logic                   mark_wait;
    logic                   hold_valid;
    logic [`SSB_DATA_W-1:0] hold_data;
    ssb_frame_t             frame;
    logic                   diag_start;
    logic                   online;
    logic [31:0]            rdata;
  } ssb_state_t;
endpackage : ssb_pkg

// *** hw/ssb_sensor.sv ***
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "ssb_regs.svh"
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Eighteen high ticks end address; ID match answers
// - Output request sends held, else fresh data
// - No-hold option stops sample holds; slot-zero option still holds
// - Sample request holds data unless no-hold
// - Sample addressing option makes sample addressed
// - Broadcast diagnostic starts self-test, no reply
// - Addressed diagnostic enters diagnostics without reply
// - Slot-zero option holds on slot zero output
// - Held data repeats until new capture or discard
// - Self-test or access takeover discards held data
// - Offline at reset, self-test, sequential-protocol contention; no drive
// - Leave offline once functional, flushed, line high
// - Addressed protocol goes offline straight to online
// - Synchronizing ignores addressing, obeys broadcast
// - Slot sync pulse: next slot zero, go online
// - Idle resync after over 510 high ticks
// - Power-on option zero: online at slot zero
// - Slot-marking sync derives slot, goes online
// - Online returns offline on test or sequential-protocol contention
// - Slot counts addressing pulses, wraps past max
module ssb_sensor
  import ssb_pkg::*;
#(
  parameter int TICK_CYCLES = `SSB_TICK_CYC
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output      logic [31:0]            reg_rdata,
  // Shared line, sampled
  input  wire logic                   sent_in,
  // Sensor core
  input  wire logic [`SSB_DATA_W-1:0] mag_data,
  input  wire logic                   self_test,
  input  wire logic                   access_takeover,
  input  wire logic                   contention,
  // Frame request and status
  output      ssb_frame_t             frame,
  output      logic                   diag_start,
  output      logic                   bus_online
);

  ////////////////////////////////////////////////////////////////////////
  function automatic ssb_pulse_t classify(input logic [7:0] w);
    classify = PK_NONE;
    if (w >= `SSB_INC_MIN && w <= `SSB_INC_MAX)
      classify = PK_INC;
    else if (w >= `SSB_OUT_MIN && w <= `SSB_OUT_MAX)
      classify = PK_OUT;
    else if (w >= `SSB_SAMP_MIN && w <= `SSB_SAMP_MAX)
      classify = PK_SAMP;
    else if (w >= `SSB_DIAG_MIN && w <= `SSB_DIAG_MAX)
      classify = PK_DIAG;
    else if (w >= `SSB_SYNC_MIN && w <= `SSB_SYNC_MAX)
      classify = PK_SYNC;
  endfunction : classify

  function automatic logic [1:0] next_slot(input logic [1:0] sl,
                                           input logic [1:0] mx);
    next_slot = (sl >= mx) ? 2'h0 : sl + 2'h1;
  endfunction : next_slot

  function automatic logic [1:0] mark_id(input logic [9:0] h);
    if (h < `SSB_MARK_01)
      mark_id = 2'h0;
    else if (h < `SSB_MARK_12)
      mark_id = 2'h1;
    else if (h < `SSB_MARK_23)
      mark_id = 2'h2;
    else
      mark_id = 2'h3;
  endfunction : mark_id

  ////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  ssb_state_t             s;
  ssb_state_t             next_s;
  ssb_pulse_t             kind;
  ssb_pulse_t             act;
  logic                   rise;
  logic                   fall;
  logic                   tick;
  logic                   halt;
  logic                   addr;
  logic                   hv;
  logic [`SSB_DATA_W-1:0] hd;

  assign rise = s.sync2 & ~s.line_d;
  assign fall = ~s.sync2 & s.line_d;
  assign tick = (s.tick == TICK_LAST);
  assign halt = self_test | access_takeover;
  assign kind = classify(s.low_ticks);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    addr = 1'b0;
    act = PK_NONE;
    hv = s.hold_valid;
    hd = s.hold_data;
    next_s.sync1 = sent_in;
    next_s.sync2 = s.sync1;
    next_s.line_d = s.sync2;
    next_s.frame.req = 1'b0;
    next_s.diag_start = 1'b0;

    // Tick phase restarts on each edge so widths count from the edge
    next_s.tick = (tick || rise || fall) ? 16'h0000 : s.tick + 16'h0001;
    if (fall)
      next_s.low_ticks = 8'h00;
    else if (tick && !s.sync2 && s.low_ticks != 8'hFF)
      next_s.low_ticks = s.low_ticks + 8'h01;
    if (rise)
      next_s.high_ticks = 10'h000;
    else if (tick && s.sync2 && s.high_ticks != 10'h3FF)
      next_s.high_ticks = s.high_ticks + 10'h001;

    if (reg_wr && reg_addr == `SSB_CFG_ADDR) begin
      next_s.cfg = ssb_cfg_t'(reg_wdata);
      next_s.cfg.rsvd = '0;
    end
    next_s.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `SSB_CFG_ADDR:  next_s.rdata = s.cfg;
        `SSB_STAT_ADDR: next_s.rdata = {24'h0, s.mark_wait, s.collect,
                                        s.hold_valid, s.slot, s.mode};
        `SSB_HOLD_ADDR: next_s.rdata = 32'(s.hold_data);
        default:        next_s.rdata = 32'h0000_0000;
      endcase
    end

    unique case (s.mode)
      SSB_OFF: begin
        // Line must read high for the whole flush so no low is cut short
        if (s.sync2 && !halt)
          next_s.flush = (s.flush == `SSB_FLUSH) ? s.flush
                                                  : s.flush + 3'h1;
        else
          next_s.flush = 3'h0;
        if (s.flush == `SSB_FLUSH) begin
          next_s.flush = 3'h0;
          next_s.por_pend = 1'b0;
          if (!s.cfg.seq || (s.por_pend && !s.cfg.po)) begin
            next_s.mode = SSB_ON;
            next_s.slot = 2'h0;
          end else begin
            next_s.mode = SSB_SYNC;
          end
        end
      end
      SSB_SYNC, SSB_ON: begin
        if (rise) begin
          case (kind)
            PK_SAMP: begin
              if (!s.cfg.ns) begin
                hv = 1'b1;
                hd = mag_data;
              end
              addr = s.cfg.fa;
            end
            PK_OUT: begin
              addr = 1'b1;
              if (s.cfg.seq && s.cfg.zs && s.slot == 2'h0) begin
                hv = 1'b1;
                hd = mag_data;
              end
            end
            PK_DIAG: begin
              if (s.cfg.da) begin
                addr = 1'b1;
              end else begin
                next_s.diag_start = 1'b1;
                next_s.mode = SSB_OFF;
              end
            end
            PK_SYNC: begin
              if (s.cfg.seq) begin
                next_s.slot = 2'h0;
                next_s.mode = SSB_ON;
                next_s.mark_wait = 1'b0;
              end
            end
            PK_INC: begin
              if (s.collect && s.inc_cnt != 2'h3)
                next_s.inc_cnt = s.inc_cnt + 2'h1;
            end
            PK_NONE: ;
            default: ;
          endcase
          if (addr) begin
            if (!s.cfg.seq) begin
              next_s.collect = 1'b1;
              next_s.inc_cnt = 2'h0;
              next_s.pend = kind;
            end else if (s.mode == SSB_ON) begin
              if (s.slot == s.cfg.sensor_id)
                act = kind;
              next_s.slot = next_slot(s.slot, s.cfg.max_id);
            end else if (s.cfg.ss) begin
              next_s.mark_wait = 1'b1;
            end
          end
        end
        // Quiet high after the address burst closes it
        if (s.collect && s.sync2 && s.high_ticks >= `SSB_INC_END) begin
          next_s.collect = 1'b0;
          if (s.inc_cnt == s.cfg.sensor_id)
            act = s.pend;
        end
        if (fall && s.mark_wait) begin
          next_s.mark_wait = 1'b0;
          next_s.slot = next_slot(mark_id(s.high_ticks), s.cfg.max_id);
          next_s.mode = SSB_ON;
        end
        // High count still holds the idle before a pulse at its rise
        if (s.cfg.seq && s.cfg.idle_sync && s.sync2 && !rise &&
            s.high_ticks > `SSB_IDLE) begin
          next_s.slot = 2'h0;
          next_s.mode = SSB_ON;
          next_s.mark_wait = 1'b0;
        end
        case (act)
          PK_OUT, PK_SAMP: begin
            next_s.frame.req = 1'b1;
            next_s.frame.held = hv;
            next_s.frame.data = hv ? hd : mag_data;
          end
          PK_DIAG: begin
            next_s.diag_start = 1'b1;
            next_s.mode = SSB_OFF;
          end
          default: ;
        endcase
        next_s.hold_valid = hv;
        next_s.hold_data = hd;
      end
    endcase

    if (contention && s.cfg.seq && s.mode != SSB_OFF)
      next_s.mode = SSB_OFF;
    if (halt) begin
      next_s.mode = SSB_OFF;
      next_s.hold_valid = 1'b0;
    end
    if (next_s.mode == SSB_OFF) begin
      next_s.collect = 1'b0;
      next_s.mark_wait = 1'b0;
      // No reply may start as the sensor drops off the bus
      next_s.frame.req = 1'b0;
    end
    next_s.online = (next_s.mode == SSB_ON);
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
      s.mode <= SSB_OFF;
      // Pipeline starts at the idle level, so release gives no false edge
      s.sync1 <= 1'b1;
      s.sync2 <= 1'b1;
      s.line_d <= 1'b1;
      s.por_pend <= 1'b1;
      s.cfg <= ssb_cfg_t'(`SSB_CFG_RST);
      s.pend <= PK_NONE;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign frame = s.frame;
  assign diag_start = s.diag_start;
  assign bus_online = s.online;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence pulse_s(ssb_pulse_t k);
    rise && kind == k && s.mode != SSB_OFF && !halt && !contention;
  endsequence

  sequence seq_sync_s;
    s.mode == SSB_SYNC && s.cfg.seq;
  endsequence

  frame_online_a: assert property (
    s.frame.req |-> $past(s.mode) == SSB_ON)
    else $error("frame request while not online");

  halt_discard_a: assert property (
    halt |=> !s.hold_valid && s.mode == SSB_OFF)
    else $error("halt kept held data or stayed on");

  ns_no_hold_a: assert property (
    $rose(s.hold_valid) |-> !$past(s.cfg.ns) || $past(s.cfg.zs))
    else $error("hold captured with no-hold option");

  fresh_data_a: assert property (
    s.frame.req && s.cfg.ns && !s.cfg.zs |-> !s.frame.held)
    else $error("held data sent under no-hold option");

  inc_end_a: assert property (
    $fell(s.collect) && s.mode != SSB_OFF
      |-> $past(s.high_ticks) >= `SSB_INC_END)
    else $error("address burst closed too early");

  slot_sync_a: assert property (
    pulse_s(PK_SYNC) and s.cfg.seq |=> s.slot == 2'h0 && s.online)
    else $error("sync pulse did not align slot");

  diag_bcast_a: assert property (
    pulse_s(PK_DIAG) and !s.cfg.da |=> s.diag_start && !s.frame.req
      ##1 !s.online)
    else $error("broadcast diagnostic not started");

  sync_silent_a: assert property (
    seq_sync_s ##0 rise && kind == PK_OUT |=> !s.frame.req)
    else $error("addressed reply while synchronizing");

  addressed_shared_protocol_direct_a: assert property (
    s.mode == SSB_OFF && s.flush == `SSB_FLUSH && !s.cfg.seq && !halt
      |=> s.mode == SSB_ON)
    else $error("addressed protocol did not go online");

  flush_exit_a: assert property (
    s.mode == SSB_OFF ##1 s.mode != SSB_OFF
      |-> $past(s.flush) == `SSB_FLUSH)
    else $error("left offline before flush");

  slot_range_a: assert property (
    s.online && $changed(s.slot) && $stable(s.cfg.max_id)
      |-> s.slot <= s.cfg.max_id)
    else $error("slot passed highest sensor id");

  idle_sync_a: assert property (
    seq_sync_s ##0 s.cfg.idle_sync && s.sync2 && !rise &&
      s.high_ticks > `SSB_IDLE && !halt && !contention
      |=> s.slot == 2'h0 && s.mode == SSB_ON)
    else $error("idle resync missed");

endmodule : ssb_sensor

// *** dv/ssb_host_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module ssb_host_model #(
  parameter int T = 4
) (
  // Clock
  input  wire logic clk,
  // Shared line, host side
  output      logic line
);
  // Line is always driven, so no floating level to model
  initial line = 1'b1;

  task automatic hold(input logic v, input int ticks);
    line <= v;
    repeat (ticks * T) @(posedge clk);
  endtask : hold

  // Function pulse, 0..3 address pulses, then long high to end the address
  task automatic poll(input int width, input int n_inc);
    hold(1'b0, width);
    for (int i = 0; i < n_inc; i++) begin
      hold(1'b1, 4);
      hold(1'b0, 5);
    end
    hold(1'b1, 30);
  endtask : poll
endmodule : ssb_host_model

// *** dv/ssb_sensor_tb.sv ***
`timescale 1ns/1ps
`include "ssb_regs.svh"
////////////////////////////////////////////////////////////////////////////
module ssb_sensor_tb;
  import ssb_pkg::*;
  logic        clk, sys_rst, reg_wr, reg_rd, sent_in;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, sd;
  logic [15:0] mag_data;
  logic        self_test, access_takeover, contention;
  logic        diag_start, bus_online, got_req, got_diag;
  ssb_frame_t  frame, seen;
  int          n_fail;
  int          n_compared;

  ssb_sensor #(.TICK_CYCLES(4)) ssb_sensor_i (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sent_in(sent_in), .mag_data(mag_data),
    .self_test(self_test), .access_takeover(access_takeover),
    .contention(contention), .frame(frame), .diag_start(diag_start),
    .bus_online(bus_online)
  );
  ssb_host_model #(.T(4)) ssb_host_model_i (.clk(clk), .line(sent_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pulses last one cycle, so latch them for the scenario to judge later
  always @(posedge clk) begin
    if (frame.req === 1'b1) begin
      got_req <= 1'b1;
      seen    <= frame;
    end
    if (diag_start === 1'b1) got_diag <= 1'b1;
  end

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string w, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 sd = reg_rdata;
    @(posedge clk);
  endtask : rd

  task automatic stat(input ssb_mode_t m);
    rd(`SSB_STAT_ADDR);
    chk("mode", {29'h0, m}, {29'h0, sd[2:0]});
  endtask : stat

  // Sampling on the falling edge keeps clear of the design's own updates
  task automatic wait_on(input logic v, input int b);
    int i;
    for (i = 0; i < b && bus_online !== v; i++) @(negedge clk);
    chk("online", {31'h0, v}, {31'h0, bus_online});
    @(posedge clk);
    if (i == b) complete_run();
  endtask : wait_on

  task automatic poll(input int w, input int n);
    got_req  <= 1'b0;
    got_diag <= 1'b0;
    ssb_host_model_i.poll(w, n);
  endtask : poll

  // Host timeout watch: no request latched means no reply came
  task automatic expf(input logic r, input logic h, input logic [15:0] d);
    chk("req", {31'h0, r}, {31'h0, got_req});
    if (r) begin
      chk("held", {31'h0, h}, {31'h0, seen.held});
      chk("data", {16'h0, d}, {16'h0, seen.data});
    end
  endtask : expf

  task automatic t_reset;
    repeat (10) @(posedge clk);
    chk("online", 32'h0, {31'h0, bus_online});
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`SSB_CFG_ADDR);
    chk("cfg", `SSB_CFG_RST, sd);
    rd(8'h0C);
    chk("unmapped", 32'h0, sd);
    wait_on(1'b1, 40);
    stat(SSB_ON);
    $display("done reset");
  endtask : t_reset

  task automatic t_addr;
    wr(`SSB_CFG_ADDR, 32'h0000_0E00);
    mag_data <= 16'h1234;
    poll(20, 1);
    expf(1'b0, 1'b0, 16'h0);
    poll(20, 2);
    expf(1'b1, 1'b0, 16'h1234);
    poll(20, 3);
    expf(1'b0, 1'b0, 16'h0);
    $display("done addressed");
  endtask : t_addr

  task automatic t_hold;
    mag_data <= 16'h5A5A;
    poll(48, 0);
    expf(1'b0, 1'b0, 16'h0);
    mag_data <= 16'h0F0F;
    poll(20, 2);
    expf(1'b1, 1'b1, 16'h5A5A);
    poll(20, 2);
    expf(1'b1, 1'b1, 16'h5A5A);
    rd(`SSB_HOLD_ADDR);
    chk("hold", 32'h0000_5A5A, sd);
    wr(`SSB_CFG_ADDR, 32'h0000_0E04);
    mag_data <= 16'h1111;
    poll(48, 2);
    expf(1'b1, 1'b1, 16'h1111);
    access_takeover <= 1'b1;
    repeat (4) @(posedge clk);
    access_takeover <= 1'b0;
    wait_on(1'b1, 40);
    mag_data <= 16'h2222;
    poll(20, 2);
    expf(1'b1, 1'b0, 16'h2222);
    wr(`SSB_CFG_ADDR, 32'h0000_0E02);
    mag_data <= 16'h3333;
    poll(48, 0);
    mag_data <= 16'h4444;
    poll(20, 2);
    expf(1'b1, 1'b0, 16'h4444);
    $display("done hold");
  endtask : t_hold

  task automatic t_test;
    wr(`SSB_CFG_ADDR, 32'h0000_0E00);
    mag_data <= 16'h6666;
    poll(48, 0);
    self_test <= 1'b1;
    wait_on(1'b0, 20);
    self_test <= 1'b0;
    wait_on(1'b1, 40);
    mag_data <= 16'h7777;
    poll(20, 2);
    expf(1'b1, 1'b0, 16'h7777);
    poll(63, 0);
    expf(1'b0, 1'b0, 16'h0);
    chk("diag", 32'h1, {31'h0, got_diag});
    wr(`SSB_CFG_ADDR, 32'h0000_0E08);
    poll(63, 1);
    chk("diag", 32'h0, {31'h0, got_diag});
    poll(63, 2);
    expf(1'b0, 1'b0, 16'h0);
    chk("diag", 32'h1, {31'h0, got_diag});
    $display("done self test");
  endtask : t_test

  task automatic t_seq;
    wr(`SSB_CFG_ADDR, 32'h0000_0D31);
    self_test <= 1'b1;
    wait_on(1'b0, 40);
    self_test <= 1'b0;
    repeat (20) @(posedge clk);
    stat(SSB_SYNC);
    poll(20, 0);
    expf(1'b0, 1'b0, 16'h0);
    poll(104, 0);
    stat(SSB_ON);
    chk("slot", 32'h0, {30'h0, sd[4:3]});
    mag_data <= 16'h8888;
    poll(20, 0);
    expf(1'b0, 1'b0, 16'h0);
    mag_data <= 16'h9999;
    poll(20, 0);
    expf(1'b1, 1'b1, 16'h8888);
    poll(20, 0);
    poll(20, 0);
    poll(48, 0);
    stat(SSB_ON);
    chk("slot", 32'h0, {30'h0, sd[4:3]});
    contention <= 1'b1;
    wait_on(1'b0, 20);
    contention <= 1'b0;
    wr(`SSB_CFG_ADDR, 32'h0000_0DB1);
    wait_on(1'b1, 2400);
    stat(SSB_ON);
    $display("done sequential");
  endtask : t_seq

  // Another sensor answers after a 20 tick mark, which names ID 1
  task automatic t_mark;
    wr(`SSB_CFG_ADDR, 32'h0000_0D61);
    contention <= 1'b1;
    wait_on(1'b0, 20);
    contention <= 1'b0;
    repeat (20) @(posedge clk);
    stat(SSB_SYNC);
    ssb_host_model_i.hold(1'b0, 20);
    ssb_host_model_i.hold(1'b1, 20);
    ssb_host_model_i.hold(1'b0, 5);
    ssb_host_model_i.hold(1'b1, 30);
    stat(SSB_ON);
    chk("slot", 32'h2, {30'h0, sd[4:3]});
    $display("done slot marking");
  endtask : t_mark

  // Reset in mid-run, then sequential protocol with the power-on option 0
  task automatic t_por;
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk);
    chk("online", 32'h0, {31'h0, bus_online});
    sys_rst <= 1'b0;
    wr(`SSB_CFG_ADDR, 32'h0000_0C01);
    wait_on(1'b1, 40);
    stat(SSB_ON);
    chk("slot", 32'h0, {30'h0, sd[4:3]});
    $display("done power on");
  endtask : t_por

  initial begin
    n_fail          = 0;
    n_compared      = 0;
    sys_rst         = 1'b1;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    reg_addr        = 8'h00;
    reg_wdata       = 32'h0;
    mag_data        = 16'h0;
    self_test       = 1'b0;
    access_takeover = 1'b0;
    contention      = 1'b0;
    got_req         = 1'b0;
    got_diag        = 1'b0;
    @(posedge clk);
    t_reset();
    t_addr();
    t_hold();
    t_test();
    t_seq();
    t_mark();
    t_por();
    complete_run();
  end
endmodule : ssb_sensor_tb
